/* rtl/vicwl_pkg.sv */
// Purpose: Shared constants for the interrupt command and write-lock slice.
// Assumes: APB with 32-bit data; offsets are full byte addresses.
// Notes: Offsets compare against the whole paddr word.
package vicwl_pkg;
  localparam int unsigned NSRC = 32;
  localparam int unsigned IDW = 5;
  // Register byte addresses.
  localparam logic [31:0] OFF_CUR_VEC = 32'hfffff100;
  localparam logic [31:0] OFF_FAST_VEC = 32'hfffff104;
  localparam logic [31:0] OFF_FORCE = 32'hfffff12c;
  localparam logic [31:0] OFF_EOS = 32'hfffff130;
  localparam logic [31:0] OFF_FALSE = 32'hfffff134;
  localparam logic [31:0] OFF_DBG = 32'hfffff138;
  localparam logic [31:0] OFF_FF_ON = 32'hfffff140;
  localparam logic [31:0] OFF_FF_OFF = 32'hfffff144;
  localparam logic [31:0] OFF_FF_ST = 32'hfffff148;
  localparam logic [31:0] OFF_ENABLE = 32'hfffff150;
  localparam logic [31:0] OFF_PEND = 32'hfffff154;
  localparam logic [31:0] OFF_LOCK_MODE = 32'hfffff1e4;
  localparam logic [31:0] OFF_LOCK_STAT = 32'h0ffff1e8;
  // Field positions and values.
  localparam logic [23:0] LOCK_KEY = 24'h414943;
  localparam int unsigned KEY_LSB = 8;
  localparam int unsigned LOCK_EN_BIT = 0;
  localparam int unsigned DBG_SAFE_BIT = 0;
  localparam int unsigned DBG_MASK_BIT = 1;
  localparam int unsigned VIOL_FLAG_BIT = 0;
  localparam int unsigned VIOL_SRC_LSB = 8;
  localparam int unsigned VIOL_SRC_W = 16;
  localparam int unsigned FAST_SRC = 0;
  localparam logic [31:0] FF_VALID = 32'hfffffffe;
  localparam logic [31:0] FAST_ONLY = 32'h00000001;
  // Reset values.
  localparam logic [31:0] FALSE_VEC_RST = 32'h00000000;
  localparam logic [1:0] DBG_RST = 2'h0;
  localparam logic [31:0] ZERO32 = 32'h00000000;
  // Service state of the normal request path.
  typedef enum logic {SVC_IDLE, SVC_BUSY} vicwl_svc_t;
endpackage

/* rtl/vicwl_top.sv */
// Purpose: Command, false-vector, debug, fast-routing and write-lock slice
//   of a vectored interrupt controller, reached over APB.
// Assumes: One clock core_clk at 50 MHz, synchronous active-low resetn.
// Notes: Sources are level inputs synchronised by three flops.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module vicwl_top (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] src_in,
  output logic normal_request_out_n,
  output logic fast_request_out_n,
  output logic irq_out,
  output logic end_service_pulse
);

  // Lowest set bit index; used for the normal and the fast path.
  function automatic logic [vicwl_pkg::IDW-1:0] first_bit(input logic [31:0] v);
    logic [vicwl_pkg::IDW-1:0] idx;
    idx = '0;
    for (int i = vicwl_pkg::NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = vicwl_pkg::IDW'(i);
      end
    end
    return idx;
  endfunction

  // One-hot word for a source index.
  function automatic logic [31:0] onehot(input logic [vicwl_pkg::IDW-1:0] id);
    return 32'h00000001 << id;
  endfunction

  logic [31:0] src_s1_r, src_s2_r, src_s3_r, src_lvl_r, src_lvl_nxt;
  logic [31:0] pending_r, pending_nxt, enable_r, ff_r, ff_nxt;
  logic [31:0] false_vec_r, prdata_r, rdata;
  logic [1:0] dbg_r;
  logic lock_en_r, viol_r, viol_nxt;
  logic [vicwl_pkg::VIOL_SRC_W-1:0] viol_src_r, viol_src_nxt;
  logic [vicwl_pkg::IDW-1:0] cur_id_r;
  vicwl_pkg::vicwl_svc_t svc_r, svc_nxt;
  logic pready_r, pslverr_r, nreq_n_r, freq_n_r, irq_r, eos_r;

  // Bus phase decode. Every access takes one wait state so read data
  // and the error answer can come straight from flops.
  wire logic acc_done = psel & penable & pready_r;
  wire logic acc_prep = psel & penable & ~pready_r;
  wire logic wr = acc_done & pwrite;
  wire logic rd = acc_done & ~pwrite;

  // Address decode.
  wire logic hit_cur = paddr == vicwl_pkg::OFF_CUR_VEC;
  wire logic hit_fast = paddr == vicwl_pkg::OFF_FAST_VEC;
  wire logic hit_force = paddr == vicwl_pkg::OFF_FORCE;
  wire logic hit_eos = paddr == vicwl_pkg::OFF_EOS;
  wire logic hit_false = paddr == vicwl_pkg::OFF_FALSE;
  wire logic hit_dbg = paddr == vicwl_pkg::OFF_DBG;
  wire logic hit_ffon = paddr == vicwl_pkg::OFF_FF_ON;
  wire logic hit_ffoff = paddr == vicwl_pkg::OFF_FF_OFF;
  wire logic hit_ffst = paddr == vicwl_pkg::OFF_FF_ST;
  wire logic hit_en = paddr == vicwl_pkg::OFF_ENABLE;
  wire logic hit_pend = paddr == vicwl_pkg::OFF_PEND;
  wire logic hit_lmode = paddr == vicwl_pkg::OFF_LOCK_MODE;
  wire logic hit_lstat = paddr == vicwl_pkg::OFF_LOCK_STAT;
  wire logic mapped = hit_cur | hit_fast | hit_force | hit_eos | hit_false | hit_dbg
    | hit_ffon | hit_ffoff | hit_ffst | hit_en | hit_pend | hit_lmode | hit_lstat;

  // Write protection decode.
  wire logic debug_safe_mode_hit = hit_false | hit_dbg;
  wire logic debug_safe_mode_ok = wr & debug_safe_mode_hit & ~lock_en_r;
  wire logic violation = wr & debug_safe_mode_hit & lock_en_r;
  wire logic key_ok = pwdata[31:vicwl_pkg::KEY_LSB] == vicwl_pkg::LOCK_KEY;
  wire logic lock_wr = wr & hit_lmode & key_ok;
  wire logic stat_rd = rd & hit_lstat;

  // Debug control fields.
  wire logic dbg_safe = dbg_r[vicwl_pkg::DBG_SAFE_BIT];
  wire logic gmask = dbg_r[vicwl_pkg::DBG_MASK_BIT];

  // Routing: bit 0 is always fast; others go fast when forced.
  wire logic [31:0] live = pending_r & enable_r;
  wire logic [31:0] fast_vec = live & (ff_r | vicwl_pkg::FAST_ONLY);
  wire logic [31:0] norm_vec = live & ~ff_r & ~vicwl_pkg::FAST_ONLY;
  wire logic cur_valid = |norm_vec;
  wire logic fast_valid = |fast_vec;
  wire logic [vicwl_pkg::IDW-1:0] norm_id = first_bit(norm_vec);
  wire logic [vicwl_pkg::IDW-1:0] fast_id = first_bit(fast_vec);

  // Entering service: a read normally, a write in debug-safe mode so a
  // debugger peeking at the vector does not disturb the handler state.
  wire logic take_rd = rd & hit_cur & ~dbg_safe;
  wire logic take_wr = wr & hit_cur & dbg_safe;
  wire logic enter = (take_rd | take_wr) & cur_valid & (svc_r == vicwl_pkg::SVC_IDLE);
  wire logic eos_wr = wr & hit_eos;

  // Pending update; a hardware or software set wins over any clear.
  wire logic [31:0] set_w = src_lvl_r | (wr & hit_force ? pwdata : vicwl_pkg::ZERO32);
  wire logic [31:0] clr_w = (wr & hit_pend ? pwdata : vicwl_pkg::ZERO32)
    | (eos_wr && svc_r == vicwl_pkg::SVC_BUSY ? onehot(cur_id_r) : vicwl_pkg::ZERO32);
  assign pending_nxt = (pending_r & ~clr_w) | set_w;

  // Fast forcing: set wins if the same bit is in both commands.
  wire logic [31:0] ff_on = wr & hit_ffon ? pwdata & vicwl_pkg::FF_VALID : vicwl_pkg::ZERO32;
  wire logic [31:0] ff_off = wr & hit_ffoff ? pwdata & vicwl_pkg::FF_VALID : vicwl_pkg::ZERO32;
  assign ff_nxt = (ff_r & ~ff_off) | ff_on;

  // Source filter: a bit changes once the second and third flops agree.
  assign src_lvl_nxt = (src_s2_r & src_s3_r) | (src_lvl_r & (src_s2_r | src_s3_r));

  // Violation status; a new violation beats the read clear.
  assign viol_nxt = violation | (viol_r & ~stat_rd);
  assign viol_src_nxt = violation ? paddr[vicwl_pkg::VIOL_SRC_W-1:0]
    : (stat_rd ? '0 : viol_src_r);

  // Service state machine.
  always_comb begin
    svc_nxt = svc_r;
    unique case (svc_r)
      vicwl_pkg::SVC_IDLE: begin
        if (enter) begin
          svc_nxt = vicwl_pkg::SVC_BUSY;
        end
      end
      vicwl_pkg::SVC_BUSY: begin
        if (eos_wr) begin
          svc_nxt = vicwl_pkg::SVC_IDLE;
        end
      end
    endcase
  end

  // Read mux; write-only words and reserved bits read as zero.
  always_comb begin
    rdata = vicwl_pkg::ZERO32;
    if (hit_cur) begin
      if (svc_r == vicwl_pkg::SVC_BUSY) begin
        rdata = {27'h0, cur_id_r};
      end else if (cur_valid) begin
        rdata = {27'h0, norm_id};
      end else begin
        rdata = false_vec_r;
      end
    end else if (hit_fast) begin
      rdata = fast_valid ? {27'h0, fast_id} : false_vec_r;
    end else if (hit_false) begin
      rdata = false_vec_r;
    end else if (hit_dbg) begin
      rdata = {30'h0, dbg_r};
    end else if (hit_ffst) begin
      rdata = ff_r;
    end else if (hit_en) begin
      rdata = enable_r;
    end else if (hit_pend) begin
      rdata = pending_r;
    end else if (hit_lmode) begin
      rdata = {31'h0, lock_en_r};
    end else if (hit_lstat) begin
      rdata = {8'h0, viol_src_r, 7'h0, viol_r};
    end
  end

  // Source synchroniser.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      src_s1_r <= '0;
      src_s2_r <= '0;
      src_s3_r <= '0;
      src_lvl_r <= '0;
    end else begin
      src_s1_r <= src_in;
      src_s2_r <= src_s1_r;
      src_s3_r <= src_s2_r;
      src_lvl_r <= src_lvl_nxt;
    end
  end

  // APB answer: ready and data one cycle into the access phase.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= acc_prep;
      pslverr_r <= acc_prep & ~mapped;
      prdata_r <= acc_prep & ~pwrite ? rdata : vicwl_pkg::ZERO32;
    end
  end

  // Software-written configuration.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      false_vec_r <= vicwl_pkg::FALSE_VEC_RST;
      dbg_r <= vicwl_pkg::DBG_RST;
      lock_en_r <= 1'b0;
      enable_r <= '0;
      ff_r <= '0;
    end else begin
      if (debug_safe_mode_ok && hit_false) begin
        false_vec_r <= pwdata;
      end
      if (debug_safe_mode_ok && hit_dbg) begin
        dbg_r <= pwdata[vicwl_pkg::DBG_MASK_BIT:vicwl_pkg::DBG_SAFE_BIT];
      end
      if (lock_wr) begin
        lock_en_r <= pwdata[vicwl_pkg::LOCK_EN_BIT];
      end
      if (wr && hit_en) begin
        enable_r <= pwdata;
      end
      ff_r <= ff_nxt;
    end
  end

  // Pending, service and violation state.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pending_r <= '0;
      svc_r <= vicwl_pkg::SVC_IDLE;
      cur_id_r <= '0;
      viol_r <= 1'b0;
      viol_src_r <= '0;
    end else begin
      pending_r <= pending_nxt;
      svc_r <= svc_nxt;
      cur_id_r <= enter ? norm_id : cur_id_r;
      viol_r <= viol_nxt;
      viol_src_r <= viol_src_nxt;
    end
  end

  // Request outputs; the global mask forces both inactive.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      nreq_n_r <= 1'b1;
      freq_n_r <= 1'b1;
      irq_r <= 1'b0;
      eos_r <= 1'b0;
    end else begin
      nreq_n_r <= ~(cur_valid & (svc_r == vicwl_pkg::SVC_IDLE) & ~gmask);
      freq_n_r <= ~(fast_valid & ~gmask);
      irq_r <= |live;
      eos_r <= eos_wr;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign normal_request_out_n = nreq_n_r;
  assign fast_request_out_n = freq_n_r;
  assign irq_out = irq_r;
  assign end_service_pulse = eos_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  chk_force_sets_pend: assert property (
    wr && hit_force |=> (pending_r & $past(pwdata)) == $past(pwdata))
    else $error("Set command did not make sources pending.");

  chk_eos_ends_svc: assert property (
    wr && hit_eos |=> svc_r == vicwl_pkg::SVC_IDLE && end_service_pulse)
    else $error("End of service did not end the handler.");

  chk_spur_vector: assert property (
    acc_prep && !pwrite && hit_cur && !cur_valid && svc_r == vicwl_pkg::SVC_IDLE
    |=> prdata == $past(false_vec_r))
    else $error("Spurious read did not return the false vector.");

  chk_lock_blocks: assert property (
    wr && hit_false && lock_en_r |=> $stable(false_vec_r))
    else $error("Locked write changed the false vector.");

  chk_gmask_holds: assert property (
    gmask && $past(gmask) |-> normal_request_out_n && fast_request_out_n)
    else $error("Global mask did not hold requests inactive.");

  chk_ff_on_off: assert property (
    wr && hit_ffoff |=> (ff_r & $past(pwdata) & vicwl_pkg::FF_VALID) == vicwl_pkg::ZERO32)
    else $error("Fast-route off command did not clear forcing.");

  chk_ff_bit0: assert property (
    wr && hit_ffon |=> !ff_r[vicwl_pkg::FAST_SRC] ##1 !ff_r[vicwl_pkg::FAST_SRC])
    else $error("Fast-route bit 0 was set.");

  chk_bad_key: assert property (
    wr && hit_lmode && !key_ok |=> $stable(lock_en_r))
    else $error("Wrong key changed the lock bit.");

  chk_viol_sticky: assert property (
    violation |=> viol_r && viol_src_r == $past(paddr[15:0]))
    else $error("Violation was not recorded.");

  chk_stat_clears: assert property (
    stat_rd && !violation |=> !viol_r && viol_src_r == '0)
    else $error("Lock status read did not clear the status.");

  // Read-back and routing checks; each one looks one edge after the access
  // or state that it guards, when the answer flops have been loaded.

  chk_false_write: assert property (
    debug_safe_mode_ok && hit_false |=> false_vec_r == $past(pwdata))
    else $error("Unlocked write did not load the false vector.");

  chk_fast_spur: assert property (
    acc_prep && !pwrite && hit_fast && !fast_valid |=> prdata == $past(false_vec_r))
    else $error("Spurious fast read did not return the false vector.");

  chk_dbg_write: assert property (
    debug_safe_mode_ok && hit_dbg |=> dbg_safe == $past(pwdata[vicwl_pkg::DBG_SAFE_BIT]))
    else $error("Unlocked write did not load the debug-safe bit.");

  chk_lock_dbg: assert property (
    wr && hit_dbg && lock_en_r |=> $stable(dbg_r))
    else $error("Locked write changed debug control.");

  chk_ff_on_sets: assert property (
    wr && hit_ffon
    |=> (ff_r & $past(pwdata) & vicwl_pkg::FF_VALID) == ($past(pwdata) & vicwl_pkg::FF_VALID))
    else $error("Fast-route on command did not set forcing.");

  chk_ffst_read: assert property (
    acc_prep && !pwrite && hit_ffst
    |=> prdata == $past(ff_r) && !prdata[vicwl_pkg::FAST_SRC])
    else $error("Fast-route state read did not show the forcing word.");

  chk_good_key: assert property (
    wr && hit_lmode && key_ok
    |=> lock_en_r == $past(pwdata[vicwl_pkg::LOCK_EN_BIT]))
    else $error("Keyed write did not load the lock bit.");

  chk_key_reads_zero: assert property (
    acc_prep && !pwrite && hit_lmode |=> prdata[31:vicwl_pkg::KEY_LSB] == 24'h000000)
    else $error("Lock key field did not read as zero.");

  chk_viol_read: assert property (
    acc_prep && !pwrite && hit_lstat
    |=> prdata[vicwl_pkg::VIOL_SRC_LSB +: vicwl_pkg::VIOL_SRC_W] == $past(viol_src_r))
    else $error("Lock status read did not show the violation source.");

  chk_eos_clears: assert property (
    eos_wr && svc_r == vicwl_pkg::SVC_BUSY && !src_lvl_r[cur_id_r]
    |=> !pending_r[$past(cur_id_r)])
    else $error("End of service did not clear the served source.");

  chk_fast_routes: assert property (
    fast_valid && !gmask |=> !fast_request_out_n)
    else $error("Forced source did not raise the fast request.");

endmodule
`default_nettype wire

/* verif/vicwl_src_model.sv */
// Purpose: Peripheral-source model that drives level interrupts into the slice.
// Assumes: Sources are active-high levels that change just after a clock edge.
// Notes: A level holds until the bench lowers it.
`timescale 1ns/1ps
`default_nettype none
module vicwl_src_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [31:0] level_req,
  output logic [31:0] src_in
);
  // Registered so that levels move only after an edge, like a real peripheral.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      src_in <= 32'h00000000;
    end else begin
      src_in <= level_req;
    end
  end
endmodule
`default_nettype wire

/* verif/vicwl_top_bench.sv */
// Purpose: Self-checking bench for the command and write-lock slice.
// Assumes: APB master with one wait state; sources come from the model.
// Notes: Each scenario task drives the slice and judges the result.
`timescale 1ns/1ps
`default_nettype none
module vicwl_top_bench;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] level_req = 32'h00000000;
  logic [31:0] prdata, src_in;
  logic pready, pslverr, nrm_n, fast_n, irq_out, eos_pulse;
  logic [3:0] outs;
  int failures = 0;
  int compares = 0;
  // Output bundle: normal, fast, interrupt level, end-of-service pulse.
  assign outs = {nrm_n, fast_n, irq_out, eos_pulse};
  // Free-running 50 MHz clock.
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  vicwl_top vicwl_top_inst (.core_clk(core_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_in(src_in), .normal_request_out_n(nrm_n),
    .fast_request_out_n(fast_n), .irq_out(irq_out), .end_service_pulse(eos_pulse));
  vicwl_src_model vicwl_src_model_inst (.core_clk(core_clk), .resetn(resetn),
    .level_req(level_req), .src_in(src_in));
  task automatic tally_and_finish;
    $display("Counts: compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      failures++;
      $display("MISMATCH t=%0t no ready", $time);
      tally_and_finish();
    end
    // One idle edge so the next call never drives psel twice in one step.
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    chk(rd, exp);
  endtask
  // Waits, bounded, for the masked outputs to reach a value; looks first
  // so that a one-cycle pulse still standing at the call is not missed.
  task automatic wt(input logic [3:0] m, input logic [3:0] v);
    int n;
    n = 0;
    while ((outs & m) !== v && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    chk({28'h0, outs & m}, {28'h0, v});
    if ((outs & m) !== v) begin
      tally_and_finish();
    end
  endtask
  task automatic t_reset_vals;
    rdc(vicwl_pkg::OFF_FALSE, 32'h0);
    rdc(vicwl_pkg::OFF_DBG, 32'h0);
    rdc(vicwl_pkg::OFF_FF_ST, 32'h0);
    wr(vicwl_pkg::OFF_FALSE, 32'hc0de0001);
    rdc(vicwl_pkg::OFF_FALSE, 32'hc0de0001);
  endtask
  task automatic t_fast_route;
    wr(vicwl_pkg::OFF_FF_ON, 32'hffffffff);
    rdc(vicwl_pkg::OFF_FF_ST, 32'hfffffffe);
    wr(vicwl_pkg::OFF_FF_OFF, 32'h0000000c);
    rdc(vicwl_pkg::OFF_FF_ST, 32'hfffffff2);
    wr(vicwl_pkg::OFF_FF_OFF, 32'hffffffff);
    rdc(vicwl_pkg::OFF_FF_ST, 32'h0);
  endtask
  task automatic t_force_eos;
    wr(vicwl_pkg::OFF_ENABLE, 32'h00000028);
    wr(vicwl_pkg::OFF_FORCE, 32'h00000020);
    rdc(vicwl_pkg::OFF_PEND, 32'h00000020);
    wt(4'b1010, 4'b0010);
    rdc(vicwl_pkg::OFF_CUR_VEC, 32'h5);
    wt(4'b1000, 4'b1000);
    wr(vicwl_pkg::OFF_EOS, 32'h12345678);
    wt(4'b0001, 4'b0001);
    rdc(vicwl_pkg::OFF_PEND, 32'h0);
    rdc(vicwl_pkg::OFF_CUR_VEC, 32'hc0de0001);
    rdc(vicwl_pkg::OFF_FAST_VEC, 32'hc0de0001);
  endtask
  task automatic t_global_mask;
    wr(vicwl_pkg::OFF_DBG, 32'h00000002);
    wr(vicwl_pkg::OFF_FORCE, 32'h00000020);
    wt(4'b0010, 4'b0010);
    repeat (3) @(posedge core_clk);
    chk({30'h0, outs[3:2]}, 32'h3);
    wr(vicwl_pkg::OFF_PEND, 32'h00000020);
    wt(4'b0010, 4'b0000);
    wr(vicwl_pkg::OFF_DBG, 32'h0);
  endtask
  task automatic t_fast_force;
    wr(vicwl_pkg::OFF_FF_ON, 32'h00000020);
    wr(vicwl_pkg::OFF_FORCE, 32'h00000020);
    wt(4'b1100, 4'b1000);
    rdc(vicwl_pkg::OFF_FAST_VEC, 32'h5);
    wr(vicwl_pkg::OFF_PEND, 32'h00000020);
    wr(vicwl_pkg::OFF_FF_OFF, 32'h00000020);
    wt(4'b0100, 4'b0100);
  endtask
  task automatic t_lock;
    wr(vicwl_pkg::OFF_LOCK_MODE, 32'h12345601);
    rdc(vicwl_pkg::OFF_LOCK_MODE, 32'h0);
    wr(vicwl_pkg::OFF_LOCK_MODE, {vicwl_pkg::LOCK_KEY, 8'h01});
    rdc(vicwl_pkg::OFF_LOCK_MODE, 32'h1);
    wr(vicwl_pkg::OFF_FALSE, 32'h11111111);
    rdc(vicwl_pkg::OFF_FALSE, 32'hc0de0001);
    wr(vicwl_pkg::OFF_DBG, 32'h00000001);
    rdc(vicwl_pkg::OFF_DBG, 32'h0);
    rdc(vicwl_pkg::OFF_LOCK_STAT, 32'h00f13801);
    rdc(vicwl_pkg::OFF_LOCK_STAT, 32'h0);
    wr(vicwl_pkg::OFF_LOCK_MODE, {vicwl_pkg::LOCK_KEY, 8'h00});
    wr(vicwl_pkg::OFF_DBG, 32'h00000001);
    rdc(vicwl_pkg::OFF_DBG, 32'h1);
    wr(vicwl_pkg::OFF_FORCE, 32'h00000020);
    rdc(vicwl_pkg::OFF_CUR_VEC, 32'h5);
    repeat (2) @(posedge core_clk);
    wt(4'b1000, 4'b0000);
    wr(vicwl_pkg::OFF_CUR_VEC, 32'h0);
    wt(4'b1000, 4'b1000);
    wr(vicwl_pkg::OFF_EOS, 32'h0);
    rdc(vicwl_pkg::OFF_PEND, 32'h0);
    wr(vicwl_pkg::OFF_DBG, 32'h0);
  endtask
  task automatic t_src_level;
    level_req <= 32'h00000008;
    wt(4'b1010, 4'b0010);
    rdc(vicwl_pkg::OFF_CUR_VEC, 32'h3);
    level_req <= 32'h0;
    repeat (6) @(posedge core_clk);
    wr(vicwl_pkg::OFF_EOS, 32'h0);
    wt(4'b0001, 4'b0001);
    wt(4'b1010, 4'b1000);
  endtask
  task automatic t_unmapped;
    logic [31:0] rd;
    logic e;
    apb(1'b0, 32'hfffff1f0, 32'h0, rd, e);
    chk({31'h0, e}, 32'h1);
  endtask
  // Main sequence: two-cycle reset, then each scenario in turn.
  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_reset_vals();
    t_fast_route();
    t_force_eos();
    t_global_mask();
    t_fast_force();
    t_lock();
    t_src_level();
    t_unmapped();
    tally_and_finish();
  end
endmodule
`default_nettype wire
